// ---- logic/dpw_consts.vh ----
// Constants for the dual wiper register access block.
// Assumes a 100 MHz reference clock; included by every design file.
`ifndef DPW_CONSTS_VH
`define DPW_CONSTS_VH

// ==========================================================
// Serial framing
`define DPW_ID_BYTE 8'h50
`define DPW_OP_READ 4'hb
`define DPW_OP_WRITE 4'hc

// ==========================================================
// Register addresses
`define DPW_ADDR_POT0 4'h0
`define DPW_ADDR_POT1 4'h1
`define DPW_ADDR_LAST_NV 4'h6
`define DPW_ADDR_ACCESS 4'h8

// ==========================================================
// Access control fields and reset values
`define DPW_ACR_VOL_BIT 7
`define DPW_ACR_SHUTDOWN_CONTROL_N_BIT 6
`define DPW_ACR_BUSY_BIT 5
`define DPW_ACR_VOL_RST 1'b0
`define DPW_ACR_SHUTDOWN_CONTROL_N_RST 1'b1
`define DPW_WIPER_RST 8'h40
`define DPW_NV_BLANK 8'h40

// ==========================================================
// Timing
`define DPW_CLK_PERIOD_NS 10
`define DPW_NV_WRITE_TIME_MS 20
`define DPW_NV_WRITE_CYCLES ((`DPW_NV_WRITE_TIME_MS * 1000000) / `DPW_CLK_PERIOD_NS)

`endif

// ---- logic/dpw_pin_sync.v ----
// Three-stage synchroniser for a group of asynchronous pins.
// Assumes each pin is independent; a change is accepted once the
// second and third stages agree.
`include "dpw_consts.vh"

module dpw_pin_sync #(
  parameter W = 4
) (
  input wire i_ref_clk, // Reference clock
  input wire i_sys_rst, // Synchronous reset, active high
  input wire [W-1:0] i_pins, // Raw pin levels
  input wire [W-1:0] i_rst_val, // Level shown while in reset
  output reg [W-1:0] o_pins_q // Filtered levels
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer k;

  // ==========================================================
  // Stage chain; only the second stage reads the first
  always @(posedge i_ref_clk)
  begin
    s1_q <= i_pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // ==========================================================
  // Accept a bit only when stages two and three agree
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_pins_q <= i_rst_val;
    end
    else
    begin
      for (k = 0; k < W; k = k + 1)
      begin
        if (s2_q[k] == s3_q[k])
          o_pins_q[k] <= s3_q[k];
      end
    end
  end

endmodule

// ---- logic/dpw_nv_mem.v ----
// Non-volatile store: power-up values and general purpose bytes.
// Assumes a single port; read data come out of a register one cycle
// after the address. Contents survive the system reset.
`include "dpw_consts.vh"

module dpw_nv_mem #(
  parameter AW = 3,
  parameter DW = 8
) (
  input wire i_ref_clk, // Reference clock
  input wire i_we, // Write strobe
  input wire [AW-1:0] i_addr, // Word address
  input wire [DW-1:0] i_wdata, // Write data
  output reg [DW-1:0] o_rdata_q // Registered read data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer n;

  // ==========================================================
  // Blank part: every cell starts at mid scale
  initial
  begin
    for (n = 0; n < (1 << AW); n = n + 1)
      mem[n] = `DPW_NV_BLANK;
  end

  // ==========================================================
  // Read first (old word on a write), read registered
  always @(posedge i_ref_clk)
  begin
    if (i_we)
      mem[i_addr] <= i_wdata;
    o_rdata_q <= mem[i_addr];
  end

endmodule

// ---- logic/dpw_top.v ----
// Register access logic of a dual digital potentiometer, serial mode 0.
// Assumes the serial pins are asynchronous and sampled by i_ref_clk,
// whose rate must be well above eight times the shift clock.
// Contract
// R1: Address 1000b is the access control register.
// R2: Pot0 registers at 0000b, pot1 at 0001b.
// R3: Tap position comes only from wiper register.
// R4: Volatile select 1: wipers only, no NV change.
// R5: Volatile select 0: addresses 0,1 reach power-up.
// R6: Written power-up value reloads wiper after power-up.
// R7: Power-up write also loads matching wiper.
// R8: Power-up read leaves wiper unchanged.
// R9: Host sets control 40h, then writes power-up.
// R10: Host selects volatile, then reads wiper.
// R11: First byte is identification 0101_0000.
// R12: Instruction nibble 1011 read, 1100 write.
// R13: NV write after chip select rise, busy, refuse.
// R14: Control bits: volatile, shutdown_n, busy, zeros.
// R15: Invalid id or instruction: ignore transaction.
// R16: Host waits for busy clear before writing; the bench writes the control register once while busy to check the refusal.
`include "dpw_consts.vh"

module dpw_top #(
  parameter NV_WRITE_CYCLES = `DPW_NV_WRITE_CYCLES,
  parameter BUSY_W = 22
) (
  input wire i_ref_clk, // Reference clock, 100 MHz
  input wire i_sys_rst, // Synchronous reset, active high
  input wire i_spi_cs_n, // Chip select pin, active low
  input wire i_spi_sck, // Shift clock pin
  input wire i_serial_in, // Serial data in
  input wire i_shutdown_n, // Shutdown pin, active low
  output reg o_serial_out, // Serial data out
  output wire o_serial_out_oe_n, // Output enable, low while driving
  output wire [6:0] o_pot0_tap, // Tap position of pot 0
  output wire [6:0] o_pot1_tap, // Tap position of pot 1
  output reg o_shutdown, // Resistor networks in shutdown
  output wire o_nv_write_busy // Non-volatile write in progress
);

  // ==========================================================
  // Transaction and recall states
  localparam ST_ID = 3'd0;
  localparam ST_INSTR = 3'd1;
  localparam ST_WRITE = 3'd2;
  localparam ST_READ = 3'd3;
  localparam ST_IGNORE = 3'd4;

  localparam RC_RD0 = 2'd0;
  localparam RC_RD1 = 2'd1;
  localparam RC_LD1 = 2'd2;
  localparam RC_DONE = 2'd3;

  // Cut to the counter width on purpose; the default fits in 22 bits
  localparam integer BUSY_LOAD_I = NV_WRITE_CYCLES - 1;
  localparam [BUSY_W-1:0] BUSY_LOAD = BUSY_LOAD_I[BUSY_W-1:0];

  // ==========================================================
  // Functions
  // Pointer advance: past the last stored byte it rolls to zero
  function [3:0] next_ptr;
    input [3:0] p;
    begin
      if (p >= `DPW_ADDR_LAST_NV)
        next_ptr = 4'h0;
      else
        next_ptr = p + 4'h1;
    end
  endfunction

  // Read data selection for one address
  function [7:0] read_mux;
    input [3:0] a;
    input volatile_only_select;
    input [7:0] nv;
    input [7:0] w0;
    input [7:0] w1;
    input [7:0] access_control;
    begin
      if (a == `DPW_ADDR_ACCESS)
        read_mux = access_control; // [R1]
      else if (a == `DPW_ADDR_POT0)
        read_mux = volatile_only_select ? w0 : nv; // [R2] [R4] [R5] [R8]
      else if (a == `DPW_ADDR_POT1)
        read_mux = volatile_only_select ? w1 : nv; // [R2] [R4] [R5] [R8]
      else if (a <= `DPW_ADDR_LAST_NV)
        read_mux = volatile_only_select ? 8'h00 : nv;
      else
        read_mux = 8'h00;
    end
  endfunction

  // ==========================================================
  // Declarations
  wire [3:0] pins_f;
  wire cs_f;
  wire sck_f;
  wire sdi_f;
  wire shutdown_control_n_pin_f;
  reg sck_prev_q;
  reg cs_prev_q;
  reg [2:0] st_q;
  reg [2:0] bit_cnt_q;
  reg [6:0] rx_q;
  reg [3:0] ptr_q;
  reg [7:0] wiper0_q;
  reg [7:0] wiper1_q;
  reg vol_q;
  reg shutdown_control_n_q;
  reg busy_q;
  reg [BUSY_W-1:0] busy_cnt_q;
  reg pend_q;
  reg [3:0] pend_addr_q;
  reg [7:0] pend_data_q;
  reg [7:0] tx_q;
  reg [7:0] tx_next_q;
  reg fetch_q;
  reg fetch2_q;
  reg [3:0] fetch_addr_q;
  reg [1:0] rc_q;
  wire [7:0] mem_rdata;
  reg [2:0] mem_addr;
  wire commit;
  wire active;
  wire sck_rise;
  wire sck_fall;
  wire byte_done;
  wire [7:0] rx_byte;
  wire [7:0] acr_val;
  wire wr_ok;

  // ==========================================================
  // Pin synchronisers
  dpw_pin_sync #(.W(4)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_pins({i_spi_cs_n, i_spi_sck, i_serial_in, i_shutdown_n}),
    .i_rst_val(4'h9), // Idle levels: deselected, clock low, so no false edge
    .o_pins_q(pins_f)
  );

  assign cs_f = pins_f[3];
  assign sck_f = pins_f[2];
  assign sdi_f = pins_f[1];
  assign shutdown_control_n_pin_f = pins_f[0];

  // Edge detection; the port is held idle until recall completes
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck_f;
      cs_prev_q <= cs_f;
    end
  end

  assign active = ~cs_f & (rc_q == RC_DONE);
  assign sck_rise = active & sck_f & ~sck_prev_q;
  assign sck_fall = active & ~sck_f & sck_prev_q;
  assign rx_byte = {rx_q, sdi_f};
  assign byte_done = sck_rise & (bit_cnt_q == 3'd7);
  // Commit a pending non-volatile byte when chip select rises
  assign commit = pend_q & cs_f & ~cs_prev_q; // [R13]
  assign wr_ok = ~busy_q; // [R13]
  assign acr_val = {vol_q, shutdown_control_n_q, busy_q, 5'h00}; // [R14]

  // ==========================================================
  // Non-volatile store; recall, commit and fetch share one port
  always @*
  begin
    if (rc_q == RC_RD0)
      mem_addr = 3'd0;
    else if (rc_q != RC_DONE)
      mem_addr = 3'd1;
    else if (commit)
      mem_addr = pend_addr_q[2:0];
    else
      mem_addr = fetch_addr_q[2:0];
  end

  dpw_nv_mem #(.AW(3), .DW(8)) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_we(commit),
    .i_addr(mem_addr),
    .i_wdata(pend_data_q),
    .o_rdata_q(mem_rdata)
  );

  // ==========================================================
  // Receive shifter and transaction sequencing
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst | ~active)
    begin
      st_q <= ST_ID;
      bit_cnt_q <= 3'd0;
      rx_q <= 7'h00;
      ptr_q <= 4'h0;
    end
    else if (sck_rise)
    begin
      bit_cnt_q <= bit_cnt_q + 3'd1;
      rx_q <= rx_byte[6:0];
      if (byte_done)
      begin
        case (st_q)
          ST_ID:
          begin
            if (rx_byte == `DPW_ID_BYTE) // [R11]
              st_q <= ST_INSTR;
            else
              st_q <= ST_IGNORE; // [R15]
          end
          ST_INSTR:
          begin
            ptr_q <= rx_byte[3:0];
            if (rx_byte[7:4] == `DPW_OP_READ) // [R12]
              st_q <= ST_READ;
            else if (rx_byte[7:4] == `DPW_OP_WRITE) // [R12]
              st_q <= ST_WRITE;
            else
              st_q <= ST_IGNORE; // [R15]
          end
          ST_WRITE, ST_READ:
            ptr_q <= next_ptr(ptr_q);
          ST_IGNORE:
            st_q <= ST_IGNORE;
          default:
            st_q <= ST_IGNORE;
        endcase
      end
    end
  end

  // ==========================================================
  // Register writes, recall and non-volatile commit
  // Wipers are the only source of the tap outputs
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      wiper0_q <= `DPW_WIPER_RST;
      wiper1_q <= `DPW_WIPER_RST;
      vol_q <= `DPW_ACR_VOL_RST;
      shutdown_control_n_q <= `DPW_ACR_SHUTDOWN_CONTROL_N_RST;
      pend_q <= 1'b0;
      pend_addr_q <= 4'h0;
      pend_data_q <= 8'h00;
      rc_q <= RC_RD0;
    end
    else
    begin
      // Recall power-up values into the wipers
      case (rc_q)
        RC_RD0:
          rc_q <= RC_RD1;
        RC_RD1:
        begin
          wiper0_q <= mem_rdata; // [R6]
          rc_q <= RC_LD1;
        end
        RC_LD1:
        begin
          wiper1_q <= mem_rdata; // [R6]
          rc_q <= RC_DONE;
        end
        default:
          rc_q <= RC_DONE;
      endcase
      // Data byte of a write; refused whole while busy
      if (byte_done & (st_q == ST_WRITE) & wr_ok) // [R13]
      begin
        if (ptr_q == `DPW_ADDR_ACCESS)
        begin
          vol_q <= rx_byte[`DPW_ACR_VOL_BIT]; // [R1] [R14]
          shutdown_control_n_q <= rx_byte[`DPW_ACR_SHUTDOWN_CONTROL_N_BIT]; // [R14]
        end
        else if (vol_q)
        begin
          // Volatile only: no non-volatile cell is touched
          if (ptr_q == `DPW_ADDR_POT0)
            wiper0_q <= rx_byte; // [R4]
          else if (ptr_q == `DPW_ADDR_POT1)
            wiper1_q <= rx_byte; // [R4]
        end
        else if ((ptr_q <= `DPW_ADDR_LAST_NV) & ~pend_q)
        begin
          // Only the first stored byte of a frame is kept: a cell
          // takes the whole write time, so a burst cannot stream
          pend_q <= 1'b1; // [R5]
          pend_addr_q <= ptr_q;
          pend_data_q <= rx_byte;
        end
      end
      if (commit)
      begin
        pend_q <= 1'b0;
        if (pend_addr_q == `DPW_ADDR_POT0)
          wiper0_q <= pend_data_q; // [R7]
        else if (pend_addr_q == `DPW_ADDR_POT1)
          wiper1_q <= pend_data_q; // [R7]
      end
      else if (cs_f)
      begin
        pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Write-in-progress timer
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      busy_q <= 1'b0;
      busy_cnt_q <= {BUSY_W{1'b0}};
    end
    else if (commit)
    begin
      busy_q <= 1'b1; // [R13]
      busy_cnt_q <= BUSY_LOAD;
    end
    else if (busy_q)
    begin
      if (busy_cnt_q == {BUSY_W{1'b0}})
        busy_q <= 1'b0;
      else
        busy_cnt_q <= busy_cnt_q - {{(BUSY_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Read fetch: address, then registered memory data, then select
  // Three reference cycles fit well inside half a shift clock
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      fetch_q <= 1'b0;
      fetch2_q <= 1'b0;
      fetch_addr_q <= 4'h0;
      tx_next_q <= 8'h00;
    end
    else
    begin
      fetch_q <= 1'b0;
      fetch2_q <= fetch_q;
      if (byte_done & (st_q == ST_INSTR))
      begin
        fetch_q <= 1'b1;
        fetch_addr_q <= rx_byte[3:0];
      end
      else if (byte_done & (st_q == ST_READ))
      begin
        fetch_q <= 1'b1;
        fetch_addr_q <= next_ptr(ptr_q);
      end
      if (fetch2_q)
        tx_next_q <= read_mux(fetch_addr_q, vol_q, mem_rdata,
                              wiper0_q, wiper1_q, acr_val); // [R8]
    end
  end

  // ==========================================================
  // Transmit shifter; bits change on falling shift clock edges
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst | ~active)
    begin
      tx_q <= 8'h00;
    end
    else if (sck_fall & (st_q == ST_READ))
    begin
      if (bit_cnt_q == 3'd0)
        tx_q <= tx_next_q;
      else
        tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Output stage and shutdown combination
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_serial_out <= 1'b0;
      o_shutdown <= 1'b0;
    end
    else
    begin
      o_serial_out <= tx_q[7];
      o_shutdown <= ~(shutdown_control_n_pin_f & shutdown_control_n_q); // [R14]
    end
  end

  // Output driven only while selected; a floating line otherwise
  assign o_serial_out_oe_n = ~active;
  assign o_pot0_tap = wiper0_q[6:0]; // [R3]
  assign o_pot1_tap = wiper1_q[6:0]; // [R3]
  assign o_nv_write_busy = busy_q;

endmodule

// ---- tb/dpw_top_asserts.sv ----
// Checker for the wiper register block, seen only through its pins.
// Assumes one reference clock domain and the synchronous active high reset.
module dpw_top_chk #(
  parameter NV_WRITE_CYCLES = 2000000
) (
  input wire logic i_ref_clk, // Reference clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_spi_cs_n, // Chip select pin
  input wire logic i_spi_sck, // Shift clock pin
  input wire logic i_serial_in, // Serial data in
  input wire logic i_shutdown_n, // Shutdown pin
  input wire logic o_serial_out, // Serial data out
  input wire logic o_serial_out_oe_n, // Output enable
  input wire logic [6:0] o_pot0_tap, // Tap of pot 0
  input wire logic [6:0] o_pot1_tap, // Tap of pot 1
  input wire logic o_shutdown, // Shutdown state
  input wire logic o_nv_write_busy // Write in progress
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cs_hi_q;
  logic [31:0] busy_cnt_q;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================================
  // Helper counters: idle time of chip select, length of busy
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || !i_spi_cs_n)
      cs_hi_q <= 4'h0;
    else if (cs_hi_q != 4'hf)
      cs_hi_q <= cs_hi_q + 4'h1;
    busy_cnt_q <= (o_nv_write_busy && !i_sys_rst) ? busy_cnt_q + 32'h1 : 32'h0;
  end
  // ==========================================================
  // Properties
  a_shutdown_pin: assert property (!i_shutdown_n [*8] |-> o_shutdown)
    else $error("shutdown pin low but block active");
  a_busy_hold: assert property ($rose(o_nv_write_busy) |=> o_nv_write_busy [*8])
    else $error("busy flag too short");
  a_busy_len: assert property ($fell(o_nv_write_busy) |-> (busy_cnt_q >= NV_WRITE_CYCLES - 1)
    && (busy_cnt_q <= NV_WRITE_CYCLES + 1)) else $error("busy length wrong");
  a_busy_start: assert property ($rose(o_nv_write_busy) |-> i_spi_cs_n && cs_hi_q < 4'd12)
    else $error("busy started outside frame end");
  a_taps_idle: assert property (cs_hi_q == 4'hf |-> $stable(o_pot0_tap) && $stable(o_pot1_tap))
    else $error("tap moved without a transfer");
  a_busy_taps: assert property (o_nv_write_busy && $past(o_nv_write_busy) |->
    $stable(o_pot0_tap) && $stable(o_pot1_tap)) else $error("tap moved while busy");
  a_oe_idle: assert property (cs_hi_q >= 4'd6 |-> o_serial_out_oe_n)
    else $error("serial out driven while deselected");
  a_sdo_frame: assert property ($changed(o_serial_out) |-> $past(cs_hi_q) < 4'd8)
    else $error("serial out moved outside a frame");
  // Main scenarios
  c_busy: cover property ($rose(o_nv_write_busy));
  c_read: cover property ($fell(o_serial_out_oe_n));
  c_shutdown_control_n: cover property ($rose(o_shutdown));
endmodule

bind dpw_top dpw_top_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_spi_cs_n(i_spi_cs_n),
  .i_spi_sck(i_spi_sck), .i_serial_in(i_serial_in), .i_shutdown_n(i_shutdown_n),
  .o_serial_out(o_serial_out), .o_serial_out_oe_n(o_serial_out_oe_n),
  .o_pot0_tap(o_pot0_tap), .o_pot1_tap(o_pot1_tap), .o_shutdown(o_shutdown),
  .o_nv_write_busy(o_nv_write_busy));

// ---- tb/dpw_spi_host.sv ----
// Behavioural serial host, mode 0, shift clock period 80 ns.
// Assumes the bench raises i_go and holds it until o_done rises.
module dpw_spi_host (
  input wire logic i_go, // Start a frame
  input wire logic [31:0] i_frame, // Bytes, first byte on top
  input wire logic [2:0] i_nbytes, // Bytes to send
  input wire logic i_sdo, // Serial out line level
  output logic o_cs_n, // Chip select
  output logic o_sck, // Shift clock, still between frames
  output logic o_sdi, // Serial data to device
  output logic o_done, // Frame finished
  output logic [7:0] o_rx // Last eight bits read back
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
    o_done = 1'b0;
    o_rx = 8'h00;
  end
  // ==========================================================
  // Frame: delays not tied to the reference clock, but every frame starts on one of its edges, so the phase is the same each frame
  always @(posedge i_go)
  begin
    o_cs_n = 1'b0;
    #43;
    for (int i = 0; i < 8 * i_nbytes; i++)
    begin
      o_sdi = i_frame[31-i];
      #40 o_sck = 1'b1;
      #40 o_rx = {o_rx[6:0], i_sdo};
      o_sck = 1'b0;
    end
    #40 o_cs_n = 1'b1;
    // Released line must not keep its last level
    o_sdi = ~o_sdi;
    // Lands between reference clock edges, so the bench sees it cleanly
    #95 o_done = 1'b1;
    wait (!i_go);
    o_done = 1'b0;
  end
endmodule

// ---- tb/dpw_top_tb.sv ----
// Self-checking bench for the wiper register block.
// Assumes the host model drives the serial pins; results checked from a queue.
module dpw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_shutdown_n = 1'b1;
  logic go = 1'b0;
  logic rd = 1'b0;
  logic probe = 1'b0;
  logic [1:0] psel = 2'h0;
  logic [31:0] frame = 32'h0;
  logic [2:0] nb = 3'h0;
  logic cs_n, sck, sdi, done, sdo, oe_n, shutdown_control_n, busy, sdo_last, sdo_line;
  logic [7:0] rx, v0, v1;
  logic [31:0] r;
  logic [6:0] tap0, tap1;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  int seed;
  initial forever #5 i_ref_clk = ~i_ref_clk;
  // Undriven serial out shows the inverse of its last driven level
  always @(posedge i_ref_clk) if (!oe_n) sdo_last <= sdo;
  assign sdo_line = oe_n ? ~sdo_last : sdo;
  // Long write time shortened so a whole frame fits inside busy
  dpw_top #(.NV_WRITE_CYCLES(400)) uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_spi_cs_n(cs_n), .i_spi_sck(sck), .i_serial_in(sdi), .i_shutdown_n(i_shutdown_n),
    .o_serial_out(sdo), .o_serial_out_oe_n(oe_n), .o_pot0_tap(tap0), .o_pot1_tap(tap1),
    .o_shutdown(shutdown_control_n), .o_nv_write_busy(busy));
  dpw_spi_host u_host (.i_go(go), .i_frame(frame), .i_nbytes(nb), .i_sdo(sdo_line),
    .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi), .o_done(done), .o_rx(rx));
  // ==========================================================
  // Verdict and comparison
  task automatic summarize();
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_head(input logic [7:0] got);
    logic [7:0] e;
    e = exp_q.pop_front();
    total_checks++;
    if (got !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  // Watchers take the oldest expectation when a result appears
  always @(posedge done) if (rd === 1'b1) check_head(rx);
  always @(posedge i_ref_clk)
    if (probe === 1'b1) check_head(psel[1] ? {7'h00, shutdown_control_n} : {1'b0, psel[0] ? tap1 : tap0});
  // ==========================================================
  // Drivers
  task automatic xfer(input logic [31:0] f, input logic [2:0] n, input logic is_rd);
    int k;
    @(posedge i_ref_clk);
    frame <= f;
    nb <= n;
    rd <= is_rd;
    go <= 1'b1;
    for (k = 0; k < 600 && done !== 1'b1; k++) @(posedge i_ref_clk);
    if (k == 600)
    begin
      err_total++;
      summarize();
    end
    go <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer({8'h50, 4'hc, a, d, 8'h00}, 3'd3, 1'b0);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer({8'h50, 4'hb, a, 8'h00, 8'h00}, 3'd3, 1'b1);
  endtask
  task automatic tap_is(input logic [1:0] s, input logic [6:0] e);
    exp_q.push_back({1'b0, e});
    psel <= s;
    probe <= 1'b1;
    @(posedge i_ref_clk);
    probe <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge i_ref_clk);
    if (k == 1000)
    begin
      err_total++;
      summarize();
    end
  endtask
  task automatic reset_dut();
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'hbdcb1b9a;
    r = $random(seed);
    v0 = r[7:0];
    v1 = {2'b00, r[13:8]};
    reset_dut();
    tap_is(1'b0, 7'h40);
    rd_reg(4'h8, 8'h40);
    wr(4'h8, 8'hc0);
    rd_reg(4'h8, 8'hc0);
    xfer({8'h50, 8'hc0, v0, v1}, 3'd4, 1'b0);
    tap_is(1'b0, v0[6:0]);
    tap_is(1'b1, v1[6:0]);
    rd_reg(4'h1, v1);
    wr(4'h8, 8'h40);
    wr(4'h0, 8'h77);
    tap_is(1'b0, 7'h77);
    wr(4'h8, 8'hc0);
    wait_idle();
    rd_reg(4'h8, 8'h40);
    wr(4'h8, 8'hc0);
    wr(4'h0, 8'h11);
    wr(4'h8, 8'h40);
    rd_reg(4'h0, 8'h77);
    tap_is(1'b0, 7'h11);
    xfer({8'h51, 8'hc0, 8'h22, 8'h00}, 3'd3, 1'b0);
    xfer({8'h50, 8'ha0, 8'h22, 8'h00}, 3'd3, 1'b0);
    tap_is(1'b0, 7'h11);
    wr(4'h8, 8'h00);
    rd_reg(4'h8, 8'h00);
    tap_is(2'h2, 7'h01);
    i_shutdown_n <= 1'b0;
    repeat (12) @(posedge i_ref_clk);
    i_shutdown_n <= 1'b1;
    reset_dut();
    tap_is(1'b0, 7'h77);
    tap_is(1'b1, 7'h40);
    summarize();
  end
endmodule
